// >>> rtl/dr_top.sv
// What this block does
// - Forward every read delayed, prefetch or not.
// - Prefetch reads ahead, all byte lanes enabled.
// - Prefetch line, multiple, prefetchable-space reads.
// - Non-prefetch: one dword, forwarded byte enables.
// - No prefetch for I/O, config, plain space.
// - Stop at boundary, disconnect last, discard rest.
// - Flow-through runs to 4KB or frame end.
// - Memory read stops at 16 or line.
// - Read line stops at 16 or line.
// - Read multiple stops at 32 or two lines.
// - Plain reads: downstream by space, upstream programmable.
// - Latch address, command, parity, enables; retry.
// - Start at head only after posted writes.
// - Drive captured enables, or all low prefetching.
// - Repeat on retry; stop after any transfer.
// - Attempt limit reached on a retry raises system error.
// - Returned data goes to read data queue.
// - Take one dword each clock, no waits.
// - Free read buffer space limits prefetch.
// - Early repeat during prefetch enters flow-through.
// - Memory read commands alias when matching.
// - Discard completion after master timeout.
// - Four pending at most, no duplicates.
`timescale 1ns/100ps
`default_nettype none
module dr_top #(
	parameter logic [15:0] MTO_CYCLES = dr_pkg::MTO_DEFAULT // Master timeout reset value
) (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic [7:0] regAddr, // Register byte address
	input wire logic [31:0] regWdata, // Register write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [31:0] regRdata, // Read data, cycle after strobe
	input wire logic iStart, // Initiator address phase
	input wire logic [31:0] iAddr, // Initiator address
	input wire logic [3:0] iCmd, // Initiator command
	input wire logic iPar, // Initiator address parity
	input wire logic iIrdy, // Initiator ready, first data phase
	input wire logic [3:0] iBe, // Initiator byte enables
	input wire logic iFrameEnd, // Initiator ends its burst
	output logic iRetry, // Target retry to initiator
	output logic iAccept, // Repeat matched, data served
	input wire logic postedPending, // Posted writes not yet delivered
	output logic mReq, // Target bus request
	input wire logic mGnt, // Target bus grant
	output logic mStart, // Address phase on target bus
	output logic [31:0] mAddr, // Replayed address
	output logic [3:0] mCmd, // Replayed command
	output logic mPar, // Replayed address parity
	output logic [3:0] mBe, // Data phase byte enables
	output logic mIrdy, // Master ready in data phases
	output logic mLastPhase, // Final data phase
	input wire logic [31:0] tData, // Target read data
	input wire logic tTrdy, // Target data phase done
	input wire logic tRetry, // Target retry
	input wire logic tDisc, // Target disconnect
	input wire logic tAbort, // Target or master abort
	input wire logic rdSpace, // Read data queue has room
	output logic rdPush, // Push dword into read data queue
	output logic [31:0] rdData, // Dword pushed
	output logic rdDisc, // Pushed dword ends with disconnect
	output logic rdDiscard, // Drop undelivered read data
	output logic primary_system_error_out // System error, active high
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		dr_pkg::dr_state_type st;
		dr_pkg::dr_req_type cap;
		logic capPend;
		logic [31:0] ctrl;
		logic [31:0] pbase;
		logic [31:0] plim;
		logic [31:0] retryLim;
		logic [31:0] attempts;
		logic [15:0] mto;
		logic [15:0] mtoCnt;
		logic serr;
		logic flow;
		logic fEnd;
		logic got;
		logic [9:0] cur;
		logic iRetry;
		logic iAccept;
		logic mStart;
		logic [31:0] mAddr;
		logic [3:0] mCmd;
		logic mPar;
		logic [3:0] mBe;
		logic rdPush;
		logic [31:0] rdData;
		logic rdDisc;
		logic rdDiscard;
		logic [31:0] rdata;
	} dr_top_st_type;

	dr_top_st_type s_q, s_d;
	dr_q_if qi ();
	dr_pkg::dr_req_type reqNow;
	logic boundLast;
	logic reqDone;
	logic headMatch;
	logic atLim;
	logic serrSet;
	logic serrClr;

	dr_queue u_queue (
		.ref_clk(ref_clk),
		.rst(rst),
		.q(qi.store)
	);

	dr_bound u_bound (
		.dw(s_q.cur),
		.cmd(qi.head.cmd),
		.pref(qi.head.pref),
		.flow(s_q.flow),
		.cache_line_size(s_q.ctrl[7:0]),
		.last(boundLast)
	);

	// ----------------------------------------------------------------
	// Request capture and matching
	// ----------------------------------------------------------------
	always_comb begin
		reqNow = s_q.cap;
		reqNow.be = iBe;
		reqNow.pref = dr_pkg::classify(s_q.cap.cmd, s_q.cap.addr,
			s_q.pbase, s_q.plim, s_q.ctrl[dr_pkg::CTRL_UP],
			s_q.ctrl[dr_pkg::CTRL_UP_PREF]);
	end

	// Second half of a capture; only reads take this path
	assign reqDone = s_q.capPend && iIrdy && dr_pkg::isRead(s_q.cap.cmd);
	assign headMatch = !qi.empty && dr_pkg::matchReq(qi.head, reqNow);
	assign atLim = (32'(s_q.attempts + 32'h1) == s_q.retryLim);
	assign serrSet = (s_q.st == dr_pkg::ST_DATA) && tRetry && !tTrdy && !s_q.got && atLim;
	assign serrClr = regWr && (regAddr == dr_pkg::OFS_STATUS) &&
		regWdata[dr_pkg::STAT_SERR];

	assign qi.pushReq = reqNow;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.iRetry = 1'b0;
		s_d.iAccept = 1'b0;
		s_d.mStart = 1'b0;
		s_d.rdPush = 1'b0;
		s_d.rdDisc = 1'b0;
		s_d.rdDiscard = 1'b0;
		s_d.rdata = 32'h0000_0000;
		qi.push = 1'b0;
		qi.pop = 1'b0;

		if (iStart) begin
			s_d.capPend = 1'b1;
			s_d.cap.addr = iAddr;
			s_d.cap.cmd = iCmd;
			s_d.cap.par = iPar;
		end else if (s_q.capPend && iIrdy) begin
			s_d.capPend = 1'b0;
		end

		if (reqDone) begin
			if (headMatch && (s_q.st == dr_pkg::ST_HOLD)) begin
				s_d.iAccept = 1'b1;
			end else if (headMatch && (s_q.st == dr_pkg::ST_DATA) &&
				qi.head.pref && !mLastPhase) begin
				s_d.iAccept = 1'b1;
				s_d.flow = 1'b1;
			end else begin
				s_d.iRetry = 1'b1;
				qi.push = !headMatch;
			end
		end

		if (s_q.flow && iFrameEnd) begin
			s_d.fEnd = 1'b1;
		end

		case (s_q.st)
			dr_pkg::ST_IDLE: begin
				if (!qi.empty) begin
					s_d.st = dr_pkg::ST_POST;
					s_d.attempts = 32'h0000_0000;
				end
			end
			dr_pkg::ST_POST: begin
				if (!postedPending) begin
					s_d.st = dr_pkg::ST_ARB;
				end
			end
			dr_pkg::ST_ARB: begin
				if (mGnt) begin
					s_d.st = dr_pkg::ST_ADDR;
					s_d.mStart = 1'b1;
					s_d.mAddr = qi.head.addr;
					s_d.mCmd = qi.head.cmd;
					s_d.mPar = qi.head.par;
					s_d.mBe = qi.head.pref ? 4'h0 : qi.head.be;
					s_d.cur = qi.head.addr[11:2];
					s_d.flow = 1'b0;
					s_d.fEnd = 1'b0;
					s_d.got = 1'b0;
				end
			end
			dr_pkg::ST_ADDR: begin
				s_d.st = dr_pkg::ST_DATA;
			end
			dr_pkg::ST_DATA: begin
				if (tTrdy) begin
					s_d.rdPush = 1'b1;
					s_d.rdData = tData;
					s_d.got = 1'b1;
					s_d.cur = 10'(s_q.cur + 10'h001);
					if (mLastPhase || tDisc || tRetry) begin
						s_d.rdDisc = 1'b1;
						s_d.mtoCnt = 16'h0000;
						if (s_d.flow) begin
							qi.pop = 1'b1;
							s_d.st = dr_pkg::ST_IDLE;
						end else begin
							s_d.st = dr_pkg::ST_HOLD;
						end
					end
				end else if (tAbort) begin
					qi.pop = 1'b1;
					s_d.st = dr_pkg::ST_IDLE;
				end else if (tRetry || tDisc) begin
					if (s_q.got) begin
						s_d.rdDisc = 1'b0;
						s_d.mtoCnt = 16'h0000;
						s_d.st = s_q.flow ? dr_pkg::ST_IDLE : dr_pkg::ST_HOLD;
						qi.pop = s_q.flow;
					end else if (atLim) begin
						qi.pop = 1'b1;
						s_d.st = dr_pkg::ST_IDLE;
					end else begin
						s_d.attempts = 32'(s_q.attempts + 32'h1);
						s_d.st = dr_pkg::ST_ARB;
					end
				end
			end
			dr_pkg::ST_HOLD: begin
				s_d.mtoCnt = 16'(s_q.mtoCnt + 16'h0001);
				if (s_d.iAccept) begin
					qi.pop = 1'b1;
					s_d.st = dr_pkg::ST_IDLE;
				end else if (s_q.mtoCnt == 16'(s_q.mto - 16'h0001)) begin
					s_d.rdDiscard = 1'b1;
					qi.pop = 1'b1;
					s_d.st = dr_pkg::ST_IDLE;
				end
			end
			default: begin
				s_d.st = dr_pkg::ST_IDLE;
			end
		endcase

		// Set wins over a clear in the same cycle
		if (serrSet) begin
			s_d.serr = 1'b1;
		end else if (serrClr) begin
			s_d.serr = 1'b0;
		end

		// ------------------------------------------------------------
		// Register port
		// ------------------------------------------------------------
		if (regWr) begin
			if (regAddr == dr_pkg::OFS_CTRL) begin
				s_d.ctrl = {21'h000000, regWdata[10:0]};
			end else if (regAddr == dr_pkg::OFS_PBASE) begin
				s_d.pbase = regWdata;
			end else if (regAddr == dr_pkg::OFS_PLIMIT) begin
				s_d.plim = regWdata;
			end else if (regAddr == dr_pkg::OFS_RETRY) begin
				s_d.retryLim = regWdata;
			end else if (regAddr == dr_pkg::OFS_TIMEOUT) begin
				s_d.mto = regWdata[15:0];
			end
		end
		if (regRd) begin
			if (regAddr == dr_pkg::OFS_CTRL) begin
				s_d.rdata = s_q.ctrl;
			end else if (regAddr == dr_pkg::OFS_PBASE) begin
				s_d.rdata = s_q.pbase;
			end else if (regAddr == dr_pkg::OFS_PLIMIT) begin
				s_d.rdata = s_q.plim;
			end else if (regAddr == dr_pkg::OFS_RETRY) begin
				s_d.rdata = s_q.retryLim;
			end else if (regAddr == dr_pkg::OFS_TIMEOUT) begin
				s_d.rdata = {16'h0000, s_q.mto};
			end else if (regAddr == dr_pkg::OFS_STATUS) begin
				s_d.rdata = {25'h0000000, s_q.st, s_q.serr, qi.count};
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.ctrl <= dr_pkg::CTRL_RST;
			s_q.pbase <= dr_pkg::PBASE_RST;
			s_q.plim <= dr_pkg::PLIMIT_RST;
			s_q.retryLim <= dr_pkg::RETRY_RST;
			s_q.mto <= MTO_CYCLES;
			s_q.st <= dr_pkg::ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Buffer space stops prefetch early rather than stalling the target
	assign mLastPhase = (s_q.st == dr_pkg::ST_DATA) && (boundLast || !rdSpace ||
		(s_q.flow && (s_q.fEnd || iFrameEnd)));
	assign mReq = (s_q.st == dr_pkg::ST_ARB);
	assign mIrdy = (s_q.st == dr_pkg::ST_DATA);
	assign mStart = s_q.mStart;
	assign mAddr = s_q.mAddr;
	assign mCmd = s_q.mCmd;
	assign mPar = s_q.mPar;
	assign mBe = s_q.mBe;
	assign iRetry = s_q.iRetry;
	assign iAccept = s_q.iAccept;
	assign rdPush = s_q.rdPush;
	assign rdData = s_q.rdData;
	assign rdDisc = s_q.rdDisc;
	assign rdDiscard = s_q.rdDiscard;
	assign regRdata = s_q.rdata;
	assign primary_system_error_out = s_q.serr && s_q.ctrl[dr_pkg::CTRL_SERR_EN];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	retryAnswer_a: assert property (@(posedge ref_clk) disable iff (rst)
		reqDone |=> (iRetry != iAccept))
		else $error("captured read got no answer");
	replayAddr_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_q.st == dr_pkg::ST_ARB) && mGnt |=> mStart && (mAddr == $past(qi.head.addr)))
		else $error("replay address differs from capture");
	prefBe_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_q.st == dr_pkg::ST_ARB) && mGnt |=>
		(mBe == ($past(qi.head.pref) ? 4'h0 : $past(qi.head.be))))
		else $error("wrong byte enables on replay");
	postOrder_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_q.st == dr_pkg::ST_POST) && postedPending |=> (s_q.st == dr_pkg::ST_POST))
		else $error("read passed a posted write");
	pushData_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_q.st == dr_pkg::ST_DATA) && tTrdy |=> rdPush && (rdData == $past(tData)))
		else $error("returned dword not queued");
	serrFlag_a: assert property (@(posedge ref_clk) disable iff (rst)
		serrSet |=> s_q.serr [*2])
		else $error("attempt limit did not raise error");
	npOne_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_q.st == dr_pkg::ST_DATA) && !qi.head.pref |-> mLastPhase)
		else $error("non-prefetch read ran past one dword");
	holdStay_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_q.st == dr_pkg::ST_HOLD) |=>
		(s_q.st == dr_pkg::ST_HOLD) || (s_q.st == dr_pkg::ST_IDLE))
		else $error("read attempted after transfer");
	timeoutDrop_a: assert property (@(posedge ref_clk) disable iff (rst)
		rdDiscard |-> ($past(s_q.st) == dr_pkg::ST_HOLD) && (s_q.st == dr_pkg::ST_IDLE))
		else $error("discard outside timeout");
	boundNp_a: assert property (@(posedge ref_clk) disable iff (rst)
		!qi.head.pref |-> boundLast) else $error("non-prefetch read not one dword");
endmodule : dr_top
`default_nettype wire

// >>> include/dr_pkg.sv
`default_nettype none
package dr_pkg;
	// ----------------------------------------------------------------
	// Bus commands
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_MRM = 4'hC;
	localparam logic [3:0] CMD_MRL = 4'hE;
	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PBASE = 8'h04;
	localparam logic [7:0] OFS_PLIMIT = 8'h08;
	localparam logic [7:0] OFS_RETRY = 8'h0C;
	localparam logic [7:0] OFS_TIMEOUT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam int CTRL_SERR_EN = 8;
	localparam int CTRL_UP = 9;
	localparam int CTRL_UP_PREF = 10;
	localparam int STAT_SERR = 3;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] PBASE_RST = 32'h0000_0000;
	localparam logic [31:0] PLIMIT_RST = 32'h0000_0000;
	localparam logic [31:0] RETRY_RST = 32'h0100_0000;
	localparam logic [15:0] MTO_DEFAULT = 16'h8000;
	localparam logic [2:0] Q_FULL = 3'h4;
	localparam int QDEPTH = 4;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_POST = 3'b001,
		ST_ARB = 3'b011,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b110,
		ST_HOLD = 3'b111
	} dr_state_type;
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] cmd;
		logic [3:0] be;
		logic par;
		logic pref;
	} dr_req_type;
	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic isMemRead(input logic [3:0] c);
		return (c == CMD_MEM_RD) || (c == CMD_MRL) || (c == CMD_MRM);
	endfunction : isMemRead
	function automatic logic isRead(input logic [3:0] c);
		return isMemRead(c) || (c == CMD_IO_RD) || (c == CMD_CFG_RD);
	endfunction : isRead
	// Memory read commands alias to one another when matched
	function automatic logic matchReq(input dr_req_type a, input dr_req_type b);
		return (a.addr == b.addr) &&
			((a.cmd == b.cmd) || (isMemRead(a.cmd) && isMemRead(b.cmd)));
	endfunction : matchReq
	function automatic logic classify(input logic [3:0] c, input logic [31:0] a,
		input logic [31:0] base, input logic [31:0] lim, input logic up,
		input logic upPref);
		if ((c == CMD_MRL) || (c == CMD_MRM)) begin
			return 1'b1;
		end else if (c == CMD_MEM_RD) begin
			return up ? upPref : ((a >= base) && (a <= lim));
		end
		return 1'b0;
	endfunction : classify
endpackage : dr_pkg
`default_nettype wire

// >>> include/dr_q_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dr_q_if;
	logic push;
	dr_pkg::dr_req_type pushReq;
	logic pop;
	dr_pkg::dr_req_type head;
	logic empty;
	logic full;
	logic hit;
	logic [2:0] count;
	modport store (input push, pushReq, pop, output head, empty, full, hit, count);
	modport user (output push, pushReq, pop, input head, empty, full, hit, count);
endinterface : dr_q_if
`default_nettype wire

// >>> rtl/dr_queue.sv
`timescale 1ns/100ps
`default_nettype none
module dr_queue (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Async reset
	dr_q_if.store q // Queue port
);
	typedef struct packed {
		dr_pkg::dr_req_type [3:0] ent;
		logic [1:0] wp;
		logic [1:0] rp;
		logic [2:0] cnt;
	} dr_queue_st_type;
	dr_queue_st_type s_q, s_d;
	logic hitV;
	always_comb begin
		s_d = s_q;
		hitV = 1'b0;
		for (int i = 0; i < dr_pkg::QDEPTH; i++) begin
			if ((i < int'(s_q.cnt)) &&
				dr_pkg::matchReq(s_q.ent[2'(s_q.rp + 2'(i))], q.pushReq)) begin
				hitV = 1'b1;
			end
		end
		if (q.push && (s_q.cnt != dr_pkg::Q_FULL) && !hitV) begin
			s_d.ent[s_q.wp] = q.pushReq;
			s_d.wp = 2'(s_q.wp + 2'h1);
		end
		if (q.pop && (s_q.cnt != 3'h0)) begin
			s_d.rp = 2'(s_q.rp + 2'h1);
		end
		s_d.cnt = 3'(s_q.cnt
			+ {2'h0, q.push && (s_q.cnt != dr_pkg::Q_FULL) && !hitV}
			- {2'h0, q.pop && (s_q.cnt != 3'h0)});
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign q.head = s_q.ent[s_q.rp];
	assign q.empty = (s_q.cnt == 3'h0);
	assign q.full = (s_q.cnt == dr_pkg::Q_FULL);
	assign q.hit = hitV;
	assign q.count = s_q.cnt;
	depthLimit_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.cnt <= dr_pkg::Q_FULL) else $error("queue deeper than four");
	noDupPush_a: assert property (@(posedge ref_clk) disable iff (rst)
		q.push && hitV && !q.pop |=> s_q.cnt == $past(s_q.cnt))
		else $error("duplicate request queued");
endmodule : dr_queue
`default_nettype wire

// >>> rtl/dr_bound.sv
`timescale 1ns/100ps
`default_nettype none
module dr_bound (
	input wire logic [9:0] dw, // Dword index in 4KB page
	input wire logic [3:0] cmd, // Read command
	input wire logic pref, // Prefetchable
	input wire logic flow, // Flow-through active
	input wire logic [7:0] cache_line_size, // Cache line size
	output logic last // This phase hits a boundary
);
	logic [10:0] size;
	logic [9:0] mask;
	logic clsOk;
	always_comb begin
		clsOk = (cache_line_size == 8'h01) || (cache_line_size == 8'h02) || (cache_line_size == 8'h04) ||
			(cache_line_size == 8'h08) || (cache_line_size == 8'h10);
		size = clsOk ? {3'h0, cache_line_size} : 11'h010;
		if (cmd == dr_pkg::CMD_MRM) begin
			size = 11'(size << 1);
		end
		mask = 10'(size - 11'h001);
		if (!pref) begin
			mask = 10'h000;
		end else if (flow) begin
			mask = 10'h3FF;
		end
		last = ((dw & mask) == mask);
	end
endmodule : dr_bound
`default_nettype wire

// >>> verif/dr_target_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Target on the far bus
// ----------------------------------------
module dr_target_model (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic mStart, // Address phase
	input wire logic [31:0] mAddr, // Replayed address
	input wire logic mIrdy, // Master ready
	input wire logic mLastPhase, // Final data phase
	input wire logic [7:0] nRetry, // Retries before data
	input wire logic slow, // Ready every other cycle
	output logic [31:0] tData, // Read data
	output logic tTrdy, // Data phase done
	output logic tRetry, // Target retry
	output logic tDisc, // Disconnect, unused
	output logic tAbort // Abort, unused
);
	logic act, run, ph;
	logic [9:0] idx, n;
	logic [7:0] rCnt;
	assign tDisc = 1'h0;
	assign tAbort = 1'h0;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			run <= 1'h0;
			idx <= 10'h000;
			ph <= 1'h0;
			rCnt <= 8'h00;
			tTrdy <= 1'h0;
			tRetry <= 1'h0;
			tData <= 32'h0;
		end else begin
			act = run;
			n = idx;
			if (mStart) begin
				n = 10'h000;
				act = rCnt >= nRetry;
				rCnt <= act ? 8'h00 : rCnt + 8'h01;
			end else if (tTrdy && mIrdy) begin
				n = idx + 10'h001;
				act = run && !mLastPhase;
			end
			run <= act;
			idx <= n;
			ph <= !ph;
			tRetry <= mStart && !act;
			tTrdy <= act && (!slow || ph);
			// Released data lines never keep the last word
			tData <= (act && (!slow || ph)) ? mAddr + {20'h0, n, 2'h0} : ~tData;
		end
	end
endmodule : dr_target_model
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic ref_clk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0, iStart = 1'h0;
	logic iPar = 1'h0, iIrdy = 1'h0, iFrameEnd = 1'h0, postedPending = 1'h0;
	logic mGnt = 1'h0, rdSpace = 1'h1, slow = 1'h0;
	logic [7:0] regAddr = 8'h00, nRetry = 8'h00;
	logic [31:0] regWdata = 32'h0, iAddr = 32'h0;
	logic [3:0] iCmd = 4'h0, iBe = 4'h0;
	logic iRetry, iAccept, mReq, mStart, mPar, mIrdy, mLastPhase, tTrdy, tRetry, tDisc;
	logic tAbort, rdPush, rdDisc, rdDiscard, primary_system_error_out;
	logic [31:0] regRdata, mAddr, tData, rdData;
	logic [3:0] mCmd, mBe;
	int miscompares = 0, nCompared = 0;
	logic [31:0] pfCtrl [7] = '{32'h4, 32'h4, 32'h4, 32'h0, 32'h10, 32'h604, 32'h204};
	logic [31:0] pfAddr [7] = '{32'h1000, 32'h1008, 32'h1000, 32'h1000, 32'h1000,
		32'h8000, 32'h8000};
	logic [3:0] pfCmd [7] = '{dr_pkg::CMD_MRL, dr_pkg::CMD_MRL, dr_pkg::CMD_MRM,
		dr_pkg::CMD_MRM, dr_pkg::CMD_MEM_RD, dr_pkg::CMD_MEM_RD, dr_pkg::CMD_MEM_RD};
	int pfN [7] = '{4, 2, 8, 32, 16, 4, 1};
	always #5 ref_clk = ~ref_clk;
	// Simple arbiter: grant one cycle after request
	always @(posedge ref_clk) mGnt <= mReq;
	dr_top #(.MTO_CYCLES(16'h0010)) dut (.ref_clk, .rst, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .iStart, .iAddr, .iCmd, .iPar, .iIrdy, .iBe, .iFrameEnd,
		.iRetry, .iAccept, .postedPending, .mReq, .mGnt, .mStart, .mAddr, .mCmd, .mPar,
		.mBe, .mIrdy, .mLastPhase, .tData, .tTrdy, .tRetry, .tDisc, .tAbort, .rdSpace,
		.rdPush, .rdData, .rdDisc, .rdDiscard, .primary_system_error_out);
	dr_target_model tgt (.ref_clk, .rst, .mStart, .mAddr, .mIrdy, .mLastPhase, .nRetry,
		.slow, .tData, .tTrdy, .tRetry, .tDisc, .tAbort);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic report_and_stop;
		if (miscompares == 0 && nCompared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic hang;
		miscompares++;
		report_and_stop();
	endtask : hang
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		regRd <= 1'h1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'h0;
		#1;
		chk(regRdata, e);
	endtask : rd
	task automatic req(input logic [31:0] a, input logic [3:0] c, be, input logic acc);
		@(posedge ref_clk);
		iStart <= 1'h1;
		iAddr <= a;
		iCmd <= c;
		iPar <= ^{a, c};
		@(posedge ref_clk);
		iStart <= 1'h0;
		iIrdy <= 1'h1;
		iBe <= be;
		@(posedge ref_clk);
		iIrdy <= 1'h0;
		#1;
		chk(32'(iAccept), 32'(acc));
		chk(32'(iRetry), 32'(!acc));
	endtask : req
	// Watches the far bus until the disconnecting word, then repeats when rep is set
	task automatic serve(input logic [31:0] a, input logic [3:0] c, be, input logic pf,
		input int n, st, input logic rep);
		int k, s, i;
		k = 0;
		s = 0;
		for (i = 0; i < 900; i++) begin
			@(posedge ref_clk);
			#1;
			if (mStart === 1'h1) begin
				s++;
				chk(mAddr, a);
				chk(32'(mCmd), 32'(c));
				chk(32'(mBe), pf ? 32'h0 : 32'(be));
			end
			if (rdPush === 1'h1) begin
				chk(rdData, a + 32'(4 * k));
				k++;
				if (rdDisc === 1'h1) break;
			end
		end
		if (i == 900) hang();
		chk(32'(k), 32'(n));
		chk(32'(s), 32'(st));
		if (rep) req(a, c, be, 1'h1);
	endtask : serve
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd(dr_pkg::OFS_RETRY, dr_pkg::RETRY_RST);
		rd(dr_pkg::OFS_TIMEOUT, 32'h10);
		rd(dr_pkg::OFS_CTRL, 32'h0);
		rd(8'h40, 32'h0);
		wr(dr_pkg::OFS_PBASE, 32'h1000);
		wr(dr_pkg::OFS_PLIMIT, 32'h1FFF);
		rd(dr_pkg::OFS_PLIMIT, 32'h1FFF);
	endtask : t_regs
	task automatic t_nonpref;
		logic [3:0] cm [3];
		int i;
		cm = '{dr_pkg::CMD_IO_RD, dr_pkg::CMD_CFG_RD, dr_pkg::CMD_MEM_RD};
		wr(dr_pkg::OFS_CTRL, 32'h4);
		for (i = 0; i < 3; i++) begin
			req(32'h3000 + 32'(16 * i), cm[i], 4'(i + 5), 1'h0);
			serve(32'h3000 + 32'(16 * i), cm[i], 4'(i + 5), 1'h0, 1, 1, 1'h1);
		end
	endtask : t_nonpref
	task automatic t_pref;
		int i;
		for (i = 0; i < 7; i++) begin
			wr(dr_pkg::OFS_CTRL, pfCtrl[i]);
			slow <= (i == 3);
			req(pfAddr[i], pfCmd[i], 4'h3, 1'h0);
			serve(pfAddr[i], pfCmd[i], 4'h3, i < 6, pfN[i], 1, 1'h1);
		end
		slow <= 1'h0;
	endtask : t_pref
	task automatic t_retry;
		nRetry <= 8'h02;
		req(32'h3100, dr_pkg::CMD_IO_RD, 4'h1, 1'h0);
		serve(32'h3100, dr_pkg::CMD_IO_RD, 4'h1, 1'h0, 1, 3, 1'h1);
		nRetry <= 8'h00;
	endtask : t_retry
	task automatic t_limit;
		int i, s;
		s = 0;
		wr(dr_pkg::OFS_RETRY, 32'h3);
		wr(dr_pkg::OFS_CTRL, 32'h100);
		nRetry <= 8'hFF;
		req(32'h3200, dr_pkg::CMD_IO_RD, 4'h2, 1'h0);
		for (i = 0; i < 200 && primary_system_error_out !== 1'h1; i++) begin
			@(posedge ref_clk);
			#1;
			s += int'(mStart === 1'h1);
		end
		if (i == 200) hang();
		chk(32'(s), 32'h3);
		rd(dr_pkg::OFS_STATUS, 32'h8);
		wr(dr_pkg::OFS_STATUS, 32'h8);
		rd(dr_pkg::OFS_STATUS, 32'h0);
		chk(32'(primary_system_error_out), 32'h0);
		nRetry <= 8'h00;
		wr(dr_pkg::OFS_RETRY, dr_pkg::RETRY_RST);
	endtask : t_limit
	task automatic t_timeout;
		int i;
		req(32'h3300, dr_pkg::CMD_IO_RD, 4'h4, 1'h0);
		serve(32'h3300, dr_pkg::CMD_IO_RD, 4'h4, 1'h0, 1, 1, 1'h0);
		for (i = 0; i < 40 && rdDiscard !== 1'h1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == 40) hang();
		chk(32'(i), 32'h10);
		rd(dr_pkg::OFS_STATUS, 32'h0);
	endtask : t_timeout
	task automatic t_space;
		wr(dr_pkg::OFS_CTRL, 32'h4);
		rdSpace <= 1'h0;
		req(32'h1000, dr_pkg::CMD_MRL, 4'h3, 1'h0);
		serve(32'h1000, dr_pkg::CMD_MRL, 4'h3, 1'h1, 1, 1, 1'h1);
		rdSpace <= 1'h1;
	endtask : t_space
	// Repeat lands while the slow target is still streaming
	task automatic t_flow;
		int i;
		wr(dr_pkg::OFS_CTRL, 32'h0);
		slow <= 1'h1;
		req(32'h1000, dr_pkg::CMD_MRM, 4'h3, 1'h0);
		repeat (6) @(posedge ref_clk);
		req(32'h1000, dr_pkg::CMD_MEM_RD, 4'h3, 1'h1);
		iFrameEnd <= 1'h1;
		@(posedge ref_clk);
		iFrameEnd <= 1'h0;
		#1;
		for (i = 0; i < 20 && !(rdPush === 1'h1 && rdDisc === 1'h1); i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == 20) hang();
		rd(dr_pkg::OFS_STATUS, 32'h0);
		slow <= 1'h0;
	endtask : t_flow
	// Posted writes owed hold the queue, so it can be filled
	task automatic t_full;
		int i;
		postedPending <= 1'h1;
		req(32'h3400, dr_pkg::CMD_IO_RD, 4'hF, 1'h0);
		req(32'h3400, dr_pkg::CMD_IO_RD, 4'hF, 1'h0);
		for (i = 1; i < 5; i++) begin
			req(32'h3400 + 32'(16 * i), dr_pkg::CMD_IO_RD, 4'hF, 1'h0);
		end
		chk(32'(mReq), 32'h0);
		rd(dr_pkg::OFS_STATUS, {25'h0, dr_pkg::ST_POST, 4'h4});
		postedPending <= 1'h0;
		for (i = 0; i < 4; i++) begin
			serve(32'h3400 + 32'(16 * i), dr_pkg::CMD_IO_RD, 4'hF, 1'h0, 1, 1, 1'h1);
		end
		rd(dr_pkg::OFS_STATUS, 32'h0);
	endtask : t_full
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'h0;
		t_regs();
		t_nonpref();
		t_pref();
		t_retry();
		t_limit();
		t_timeout();
		t_space();
		t_flow();
		t_full();
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
